// [design/mrd_pkg.sv]
// Purpose: constants for the register-window relocation decoder
// Assumes: 42-bit real address, configuration ring shifted in serially during power-on
// Notes: offsets below are the local register port map of this block
package mrd_pkg;
  // ************************************************************
  // address and field widths
  // ************************************************************
  localparam int REAL_ADDR_W = 42;
  localparam int SYN_BASE_W = 19;
  localparam int ARCH_BASE_W = 30;
  localparam int IO_BASE_W = 22;
  localparam int NUM_SYN = 8;
  // ring order: 8 synergistic, main processor, memory ctrl, pervasive, io ctrl
  localparam int RING_LEN = NUM_SYN * SYN_BASE_W + 3 * ARCH_BASE_W + IO_BASE_W;
  localparam int NUM_UNITS = NUM_SYN + 4;
  localparam int UNIT_ID_W = 4;
  localparam logic [UNIT_ID_W-1:0] UNIT_MAIN = 4'h8;
  localparam logic [UNIT_ID_W-1:0] UNIT_MEM = 4'h9;
  localparam logic [UNIT_ID_W-1:0] UNIT_PRV = 4'hA;
  localparam logic [UNIT_ID_W-1:0] UNIT_IO = 4'hB;
  localparam logic [UNIT_ID_W-1:0] UNIT_NONE = 4'hF;
  // ************************************************************
  // privilege classes
  // ************************************************************
  localparam logic [1:0] PRIV_HYP = 2'h2;
  localparam logic [1:0] PRIV_OS = 2'h1;
  localparam logic [1:0] PRIV_APP = 2'h0;
  // ************************************************************
  // local register port map
  // ************************************************************
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_SEL = 4'h1;
  localparam logic [3:0] REG_BASE = 4'h2;
  localparam logic [3:0] REG_HIT_CNT = 4'h3;
  localparam logic [31:0] RESET_SEL = 32'h0000_0000;
endpackage

// [design/mrd_base_slot.sv]
// Purpose: one relocation base field, loaded from the ring, and its window compare
// Assumes: field sits at a fixed bit position of the shifted ring image
// Notes: compare is against the top W bits of the real address
`timescale 1ns/100ps
module mrd_base_slot #(
  parameter int W = 19,
  parameter int POS = 0,
  parameter int RLEN = 10,
  parameter int AW = 42
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [RLEN-1:0] ring_in,
  input wire logic [AW-1:0] addr_in,
  output logic [W-1:0] base_out,
  output logic hit_out
);
  logic [W-1:0] base_r;
  // capture field when the ring has fully arrived
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      base_r <= '0;
    end else if (load_in) begin
      base_r <= ring_in[POS +: W];
    end
  end
  assign base_out = base_r;
  assign hit_out = (addr_in[AW-1 -: W] == base_r);
endmodule

// [design/mrd_decode.sv]
// Purpose: register-window relocation and privilege classification of accesses
// Assumes: ring bits arrive serially from logic on clk_in; requests are one-cycle pulses
// Notes: requests before the ring load completes are answered as not claimed
`timescale 1ns/100ps
// Notes on behaviour
// - load every unit base from the ring during power-on, before decoding
// - base fields supply the top bits of the 42-bit real address
// - each of eight synergistic units has its own 19-bit base
// - main processor, memory controller, pervasive logic each have 30-bit bases
// - one 22-bit io controller base covers its shared group of units
// - hypervisor bit 1, problem bit 0 is the most-trusted state
// - both bits 0 is the operating-system privileged state
// - problem bit 1 is application state regardless of hypervisor bit
// - application-state access is not gated here; page tables do it
// - reserved register bits ignore writes and read as zero
module mrd_decode import mrd_pkg::*; (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ring_valid_in,
  input wire logic ring_bit_in,
  input wire logic req_valid_in,
  input wire logic [REAL_ADDR_W-1:0] req_addr_in,
  input wire logic hypervisor_state_bit_in,
  input wire logic problem_state_bit_in,
  input wire logic [REG_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic ready_out,
  output logic claim_valid_out,
  output logic [UNIT_ID_W-1:0] claim_unit_out,
  output logic [1:0] claim_priv_out,
  output logic miss_out
);
  // ************************************************************
  // power-on ring load
  // ************************************************************
  typedef enum logic [1:0] {ST_LOAD, ST_CAPTURE, ST_RUN} mrd_state_t;
  localparam int CNT_W = $clog2(RING_LEN + 1);
  localparam logic [CNT_W-1:0] RING_LAST = CNT_W'(RING_LEN - 1);
  mrd_state_t state_r;
  mrd_state_t state_nxt;
  logic [RING_LEN-1:0] ring_r;
  logic [CNT_W-1:0] bit_cnt_r;
  wire ring_done = ring_valid_in && (bit_cnt_r == RING_LAST);
  wire load_pulse = (state_r == ST_CAPTURE);
  wire running = (state_r == ST_RUN);
  // the decoder stays blind until every field is captured
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD: begin
        if (ring_done) begin
          state_nxt = ST_CAPTURE;
        end
      end
      ST_CAPTURE: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end
  // ring shifts in msb first; image index 0 ends as the last bit shifted
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_r <= ST_LOAD;
      ring_r <= '0;
      bit_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (ring_valid_in && state_r == ST_LOAD) begin
        ring_r <= {ring_r[RING_LEN-2:0], ring_bit_in};
        bit_cnt_r <= bit_cnt_r + CNT_W'(1);
      end
    end
  end
  // ************************************************************
  // base slots and window compare
  // ************************************************************
  logic [NUM_UNITS-1:0] hit;
  logic [SYN_BASE_W-1:0] syn_base [NUM_SYN];
  logic [ARCH_BASE_W-1:0] arch_base [3];
  logic [IO_BASE_W-1:0] io_base;
  genvar gi;
  // eight synergistic slots of their own width
  generate
    for (gi = 0; gi < NUM_SYN; gi++) begin : g_syn
      mrd_base_slot #(.W(SYN_BASE_W), .POS(RING_LEN - (gi + 1) * SYN_BASE_W),
        .RLEN(RING_LEN), .AW(REAL_ADDR_W)) u_slot (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .load_in(load_pulse),
        .ring_in(ring_r),
        .addr_in(req_addr_in),
        .base_out(syn_base[gi]),
        .hit_out(hit[gi])
      );
    end
    for (gi = 0; gi < 3; gi++) begin : g_arch
      mrd_base_slot #(.W(ARCH_BASE_W),
        .POS(IO_BASE_W + (2 - gi) * ARCH_BASE_W),
        .RLEN(RING_LEN), .AW(REAL_ADDR_W)) u_slot (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .load_in(load_pulse),
        .ring_in(ring_r),
        .addr_in(req_addr_in),
        .base_out(arch_base[gi]),
        .hit_out(hit[NUM_SYN + gi])
      );
    end
  endgenerate
  // one shared io-controller slot for its group of units
  mrd_base_slot #(.W(IO_BASE_W), .POS(0), .RLEN(RING_LEN), .AW(REAL_ADDR_W)) u_io (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .load_in(load_pulse),
    .ring_in(ring_r),
    .addr_in(req_addr_in),
    .base_out(io_base),
    .hit_out(hit[NUM_UNITS-1])
  );
  // windows nest, so the longer base (the narrower window) must win over a shorter one;
  // otherwise a common top value would hand every access to synergistic slot 0
  logic [UNIT_ID_W-1:0] hit_unit;
  always_comb begin
    hit_unit = UNIT_NONE;
    for (int i = NUM_SYN - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_unit = UNIT_ID_W'(i);
      end
    end
    if (hit[NUM_UNITS-1]) begin
      hit_unit = UNIT_IO;
    end
    for (int i = NUM_UNITS - 2; i >= NUM_SYN; i--) begin
      if (hit[i]) begin
        hit_unit = UNIT_ID_W'(i);
      end
    end
  end
  // ************************************************************
  // privilege classification
  // ************************************************************
  // problem bit dominates; no gating of application accesses here
  wire [1:0] priv_class = problem_state_bit_in ? PRIV_APP :
    (hypervisor_state_bit_in ? PRIV_HYP : PRIV_OS);
  wire claim = req_valid_in && running && (hit_unit != UNIT_NONE);
  wire miss = req_valid_in && !(running && (hit_unit != UNIT_NONE));
  logic [15:0] hit_cnt_r;
  // answer one cycle after the request
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      claim_valid_out <= 1'b0;
      claim_unit_out <= UNIT_NONE;
      claim_priv_out <= PRIV_APP;
      miss_out <= 1'b0;
      ready_out <= 1'b0;
      hit_cnt_r <= '0;
    end else begin
      claim_valid_out <= claim;
      claim_unit_out <= claim ? hit_unit : UNIT_NONE;
      claim_priv_out <= req_valid_in ? priv_class : PRIV_APP;
      miss_out <= miss;
      ready_out <= running;
      if (claim) begin
        hit_cnt_r <= hit_cnt_r + 16'h0001;
      end
    end
  end
  // ************************************************************
  // register port
  // ************************************************************
  logic [3:0] sel_r;
  logic [31:0] base_view;
  // selected unit base shown right-justified; upper bits read zero
  always_comb begin
    base_view = 32'h0000_0000;
    if (sel_r < 4'(NUM_SYN)) begin
      base_view = {13'h0000, syn_base[sel_r[2:0]]};
    end else if (sel_r == UNIT_MAIN) begin
      base_view = {2'h0, arch_base[0]};
    end else if (sel_r == UNIT_MEM) begin
      base_view = {2'h0, arch_base[1]};
    end else if (sel_r == UNIT_PRV) begin
      base_view = {2'h0, arch_base[2]};
    end else if (sel_r == UNIT_IO) begin
      base_view = {10'h000, io_base};
    end
  end
  wire [31:0] rd_mux = (reg_addr_in == REG_STATUS) ? {30'h0, load_pulse, running} :
    (reg_addr_in == REG_SEL) ? {28'h0, sel_r} :
    (reg_addr_in == REG_BASE) ? base_view :
    (reg_addr_in == REG_HIT_CNT) ? {16'h0000, hit_cnt_r} : 32'h0000_0000;
  // only the unit-select field is writable; the rest is dropped
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sel_r <= RESET_SEL[3:0];
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      if (reg_wr_in && reg_addr_in == REG_SEL) begin
        sel_r <= reg_wdata_in[3:0];
      end
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
    end
  end
  // ************************************************************
  // checks
  // ************************************************************
  no_claim_early_a: assert property (@(posedge clk_in) disable iff (reset_in)
    claim_valid_out |-> $past(running))
    else $error("claim before ring load finished");
  claim_match_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (claim_valid_out && claim_unit_out < 4'(NUM_SYN)) |->
    ($past(req_addr_in[REAL_ADDR_W-1 -: SYN_BASE_W]) == syn_base[claim_unit_out[2:0]]))
    else $error("claimed window does not match base");
  io_match_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (claim_valid_out && claim_unit_out == UNIT_IO) |->
    ($past(req_addr_in[REAL_ADDR_W-1 -: IO_BASE_W]) == io_base))
    else $error("io group claim mismatch");
  hyp_class_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (req_valid_in && hypervisor_state_bit_in && !problem_state_bit_in) |=>
    (claim_priv_out == PRIV_HYP))
    else $error("hypervisor access misclassified");
  os_class_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (req_valid_in && !hypervisor_state_bit_in && !problem_state_bit_in) |=>
    (claim_priv_out == PRIV_OS))
    else $error("os access misclassified");
  app_class_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (req_valid_in && problem_state_bit_in) |=> (claim_priv_out == PRIV_APP))
    else $error("application access misclassified");
  app_not_gated_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (req_valid_in && problem_state_bit_in && running && hit_unit != UNIT_NONE) |=>
    claim_valid_out)
    else $error("application access was gated");
  load_then_run_a: assert property (@(posedge clk_in) disable iff (reset_in)
    load_pulse |=> (running && syn_base[0] == $past(ring_r[RING_LEN-1 -: SYN_BASE_W])))
    else $error("synergistic base not captured");
  arch_load_a: assert property (@(posedge clk_in) disable iff (reset_in)
    load_pulse |=> (arch_base[0] == $past(ring_r[IO_BASE_W + 2 * ARCH_BASE_W +: ARCH_BASE_W])))
    else $error("main processor base not captured");
  sel_zero_top_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in == REG_SEL) |=> (reg_rdata_out[31:4] == 28'h0))
    else $error("reserved bits read nonzero");
  miss_excl_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !(miss_out && claim_valid_out))
    else $error("claim and miss together");
endmodule

// [verification/mrd_requester_model.sv]
// Purpose: requester and ring-source model facing the relocation decoder
// Assumes: one clock; every change lands just after a rising edge
// Notes: released lines show the inverse of their last value, never a held copy
`timescale 1ns/100ps
module mrd_requester_model import mrd_pkg::*; #(
  parameter logic [18:0] TOP = 19'h2A5C3,
  parameter logic [10:0] LOW_MAIN = 11'h001,
  parameter logic [10:0] LOW_MEM = 11'h002,
  parameter logic [10:0] LOW_PRV = 11'h003,
  parameter logic [2:0] LOW_IO = 3'h5
) (
  input wire logic clk_in,
  output logic ring_valid_out,
  output logic ring_bit_out,
  output logic req_valid_out,
  output logic [REAL_ADDR_W-1:0] req_addr_out,
  output logic hyp_out,
  output logic prob_out
);
  // ************************************************************
  // ring image and requests
  // ************************************************************
  // one common top value everywhere; the low extras place each unit
  localparam logic [RING_LEN-1:0] IMAGE = {{8{TOP}}, TOP, LOW_MAIN, TOP, LOW_MEM,
    TOP, LOW_PRV, TOP, LOW_IO};
  // idle lines at time zero
  initial begin
    ring_valid_out = 1'b0;
    ring_bit_out = 1'b0;
    req_valid_out = 1'b0;
    req_addr_out = '0;
    hyp_out = 1'b0;
    prob_out = 1'b0;
  end
  // shift the image out msb first, one bit a cycle
  task automatic load_ring();
    for (int i = RING_LEN - 1; i >= 0; i--) begin
      @(posedge clk_in);
      ring_valid_out <= 1'b1;
      ring_bit_out <= IMAGE[i];
    end
    @(posedge clk_in);
    ring_valid_out <= 1'b0;
    ring_bit_out <= ~IMAGE[0];
  endtask
  // one-cycle request; qualifiers flip on release so stale values cannot match
  task automatic issue(input logic [REAL_ADDR_W-1:0] addr, input logic hv, input logic pr);
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_addr_out <= addr;
    hyp_out <= hv;
    prob_out <= pr;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    req_addr_out <= ~addr;
    hyp_out <= ~hv;
    prob_out <= ~pr;
  endtask
endmodule

// [verification/mrd_decode_tb.sv]
// Purpose: self-checking bench for the relocation decoder
// Assumes: register port answers reads in the following cycle
// Notes: longer bases win; addresses with the common top value outside the 30- and 22-bit windows land on unit 0
`timescale 1ns/100ps
module mrd_decode_tb import mrd_pkg::*; ;
  localparam logic [18:0] TOP = 19'h2A5C3;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic ring_valid, ring_bit, req_valid, hyp_bit, prob_bit;
  logic [REAL_ADDR_W-1:0] req_addr;
  logic [REG_ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic ready, claim_valid, miss;
  logic [UNIT_ID_W-1:0] claim_unit;
  logic [1:0] claim_priv;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  // ************************************************************
  // clock, instances, checking tasks
  // ************************************************************
  always #2 clk_in = ~clk_in;
  mrd_requester_model #(.TOP(TOP)) u_mrd_requester_model (.clk_in(clk_in),
    .ring_valid_out(ring_valid), .ring_bit_out(ring_bit), .req_valid_out(req_valid),
    .req_addr_out(req_addr), .hyp_out(hyp_bit), .prob_out(prob_bit));
  mrd_decode u_mrd_decode (.clk_in(clk_in), .reset_in(reset_in), .ring_valid_in(ring_valid),
    .ring_bit_in(ring_bit), .req_valid_in(req_valid), .req_addr_in(req_addr),
    .hypervisor_state_bit_in(hyp_bit), .problem_state_bit_in(prob_bit),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .ready_out(ready),
    .claim_valid_out(claim_valid), .claim_unit_out(claim_unit),
    .claim_priv_out(claim_priv), .miss_out(miss));
  task automatic end_sim();
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // request answer is registered on the taking edge and checked 1 ns later
  task automatic req(input logic [41:0] a, input logic hv, input logic pr, input logic hit);
    u_mrd_requester_model.issue(a, hv, pr);
    #1 chk({30'h0, claim_valid, miss}, {30'h0, hit, ~hit});
  endtask
  // right-justified base each unit should report
  function automatic logic [31:0] exp_base(input int u);
    if (u < NUM_SYN) exp_base = {13'h0, TOP};
    else if (u == 11) exp_base = {10'h0, TOP, 3'h5};
    else exp_base = {2'h0, TOP, u == 8 ? 11'h001 : (u == 9 ? 11'h002 : 11'h003)};
  endfunction
  // ************************************************************
  // main sequence and hang guard
  // ************************************************************
  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    reg_read(REG_STATUS, 32'h0000_0000);
    req({TOP, 23'h000000}, 1'b1, 1'b0, 1'b0);
    u_mrd_requester_model.load_ring();
    for (int n = 0; n < 10 && ready !== 1'b1; n++) @(posedge clk_in);
    chk({31'h0, ready}, 32'h0000_0001);
    reg_read(REG_STATUS, 32'h0000_0001);
    for (int u = 0; u < NUM_UNITS; u++) begin
      reg_write(REG_SEL, u);
      reg_read(REG_BASE, exp_base(u));
    end
    for (int k = 0; k < 4; k++) begin
      req({TOP, 23'h12345 + k[22:0]}, k[1], k[0], 1'b1);
      chk({28'h0, claim_unit}, 32'h0000_0000);
      chk({30'h0, claim_priv},
        {30'h0, k[0] ? PRIV_APP : (k[1] ? PRIV_HYP : PRIV_OS)});
    end
    req({TOP ^ 19'h00001, 23'h000000}, 1'b1, 1'b0, 1'b0);
    req({TOP ^ 19'h40000, 23'h7FFFFF}, 1'b0, 1'b0, 1'b0);
    // each narrower window inside the common top value claims for its own unit
    req({TOP, 11'h001, 12'h0AB}, 1'b1, 1'b0, 1'b1);
    chk({28'h0, claim_unit}, {28'h0, UNIT_MAIN});
    req({TOP, 11'h002, 12'hFFF}, 1'b0, 1'b0, 1'b1);
    chk({28'h0, claim_unit}, {28'h0, UNIT_MEM});
    req({TOP, 11'h003, 12'h000}, 1'b0, 1'b1, 1'b1);
    chk({28'h0, claim_unit}, {28'h0, UNIT_PRV});
    req({TOP, 3'h5, 20'hABCDE}, 1'b1, 1'b1, 1'b1);
    chk({28'h0, claim_unit}, {28'h0, UNIT_IO});
    chk({30'h0, claim_priv}, {30'h0, PRIV_APP});
    reg_read(REG_HIT_CNT, 32'h0000_0008);
    reg_write(REG_SEL, 32'hFFFF_FFF3);
    reg_read(REG_SEL, 32'h0000_0003);
    reg_write(REG_STATUS, 32'hFFFF_FFFF);
    reg_read(REG_STATUS, 32'h0000_0001);
    reg_read(4'h7, 32'h0000_0000);
    end_sim();
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end
endmodule
